// ---- verilog/acq_ctrl_pkg.sv ----
// Package with register map, field encodings and timing constants for the acquisition controller
package acq_ctrl_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_FREQ_MHZ = 200;
  localparam int TICK_US_CYCLES = CLK_FREQ_MHZ;  // Cycles per microsecond
  localparam int CLK_FREQ_HZ = CLK_FREQ_MHZ * 1000000;

  // ==========================================================================
  // Register byte addresses (address is a byte address, registers 4 apart)
  // ==========================================================================
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_TRIG_CFG = 8'h04;
  localparam logic [7:0] REG_MULTI_COUNT = 8'h08;
  localparam logic [7:0] REG_BURST_COUNT = 8'h0C;
  localparam logic [7:0] REG_EXPOSURE_US = 8'h10;
  localparam logic [7:0] REG_TRIG_DELAY_US = 8'h14;
  localparam logic [7:0] REG_FRAME_RATE = 8'h18;
  localparam logic [7:0] REG_ROW_RATE = 8'h1C;
  localparam logic [7:0] REG_READOUT_US = 8'h20;
  localparam logic [7:0] REG_COMMAND = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_ACHIEVED_RATE = 8'h2C;
  localparam logic [7:0] REG_IMAGE_COUNT = 8'h30;

  // CONTROL fields
  localparam int CTL_MODE_LSB = 0;  // 2 bits capture mode
  localparam int CTL_EXPMODE_BIT = 2;
  localparam int CTL_AUTO_LSB = 3;  // 2 bits auto exposure
  localparam int CTL_MANUAL_RATE_BIT = 5;
  localparam int CTL_RATE_HOLD_BIT = 6;
  // TRIG_CFG fields
  localparam int TRG_TYPE_LSB = 0;  // 2 bits
  localparam int TRG_EN_LSB = 2;  // 3 bits, one per type
  localparam int TRG_BURST_END_BIT = 5;
  localparam int TRG_ORIGIN_LSB = 8;  // 4 bits
  localparam int TRG_SENSE_LSB = 12;  // 3 bits
  localparam int TRG_OVERLAP_BIT = 15;
  // COMMAND fields
  localparam int CMD_BEGIN_BIT = 0;
  localparam int CMD_END_BIT = 1;
  localparam int CMD_HOST_TRIG_BIT = 2;

  // Reset values
  localparam logic [31:0] CONTROL_RST = 32'h0000_0018;  // Continuous, timed, auto field 3 (reserved)
  localparam logic [31:0] TRIG_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MULTI_COUNT_RST = 32'h0000_0001;
  localparam logic [31:0] BURST_COUNT_RST = 32'h0000_0001;
  localparam logic [31:0] EXPOSURE_RST = 32'h0000_2710;
  localparam logic [31:0] FRAME_RATE_RST = 32'h0000_000A;
  localparam logic [31:0] ROW_RATE_RST = 32'h0000_C350;
  localparam logic [31:0] READOUT_RST = 32'h0000_03E8;
  localparam logic [31:0] AUTO_EXP_US = 32'h0000_2710;  // Exposure picked by auto modes
  localparam int AUTO_ONCE_FRAMES = 4;

  // Origins: 0..3 lines, 4..5 user bits, 6..7 counters, 8..9 logic blocks, 10 host
  localparam int NUM_SRC = 10;
  localparam logic [3:0] ORIGIN_HOST = 4'hA;

  typedef enum logic [1:0] {CONTINUOUS_MODE, SINGLE_CAPTURE_MODE, MULTI_CAPTURE_MODE, MODE_RSVD}
    capture_mode_e;
  typedef enum logic [1:0] {AUTO_OFF, AUTO_ONCE, AUTO_CONTINUOUS, AUTO_RSVD} auto_exp_e;
  typedef enum logic [1:0] {TYPE_ACQ_START, TYPE_PER_IMAGE, TYPE_BURST_BEGIN, TYPE_RSVD}
    trig_type_e;
  typedef enum logic [2:0] {SENSE_LOW, SENSE_HIGH, SENSE_FALL, SENSE_RISE, SENSE_ANY} sense_e;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // Sensor control strobes
  typedef struct packed {
    logic exposing;
    logic readout;
    logic acq_active;
  } sensor_ctl_s;

endpackage : acq_ctrl_pkg

// ---- verilog/acq_trigger_ctrl.sv ----
// Image acquisition, exposure and trigger control block
`timescale 1ns/1ps

// Summary of operation
// [R1] Continuous, single, multi modes; continuous default
// [R2] Single mode captures one then stops; with burst trigger enabled the code returns to S_ARMED instead
// [R3] Multi mode captures programmed count then stops; with burst trigger enabled the code returns to S_ARMED instead
// [R4] Begin command starts, end command halts; the code ignores begin while the acquisition-start trigger is enabled
// [R5] Manual rate enable picks programmed rate
// [R6] Achieved rate reported, slower when exposure long
// [R7] Timed or trigger-width exposure, timed default
// [R8] Timed manual exposure uses microsecond setting
// [R9] Auto once reverts off; reset loads auto field 3 (reserved)
// [R10] Triggers disabled after reset, need enable
// [R11] Acquisition-start trigger begins selected mode
// [R12] Per-image single/multi needs new begin
// [R13] Per-image continuous: one image per trigger
// [R14] Burst trigger captures burst/one/multi count
// [R15] Burst count used only without burst-end
// [R16] Source: lines, user bits, counters, logic, host
// [R17] Low, high, fall, rise or any edge
// [R18] Overlap off ignores triggers during readout
// [R19] Delay microseconds before exposure starts
// [R20] Host trigger only when origin is host
// [R21] Rate hold keeps programmed period
// [R22] Row rate paces lines within frame
// [R23] Microsecond tick; inputs synchronised first
module acq_trigger_ctrl (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [3:0] LINE_IN,
  input wire logic [1:0] USER_BIT_IN,
  input wire logic [1:0] COUNTER_IN,
  input wire logic [1:0] LOGIC_BLOCK_IN,
  output logic [31:0] RDATA_OUT,
  output acq_ctrl_pkg::sensor_ctl_s SENSOR_OUT,
  output logic ROW_STROBE_OUT,
  output logic IMAGE_DONE_OUT
);
  import acq_ctrl_pkg::*;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [31:0] control_q, trig_cfg_q, multi_q, burst_q, exp_q, delay_q, rate_q, row_q, readout_q;
  logic [31:0] achieved_q, img_cnt_q, rdata_q;
  bus_req_s req;
  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // Field decode
  capture_mode_e mode;
  auto_exp_e auto_sel;
  trig_type_e ttype;
  sense_e sense;
  logic width_exp, manual_rate, rate_hold, burst_end_en, overlap, trig_en;
  logic [3:0] origin;
  assign mode = capture_mode_e'(control_q[CTL_MODE_LSB +: 2]);  // [R1]
  assign width_exp = control_q[CTL_EXPMODE_BIT];  // [R7]
  assign auto_sel = auto_exp_e'(control_q[CTL_AUTO_LSB +: 2]);
  assign manual_rate = control_q[CTL_MANUAL_RATE_BIT];
  assign rate_hold = control_q[CTL_RATE_HOLD_BIT];
  assign ttype = trig_type_e'(trig_cfg_q[TRG_TYPE_LSB +: 2]);
  assign trig_en = trig_cfg_q[TRG_EN_LSB + 32'(ttype)] && (ttype != TYPE_RSVD);  // [R10]
  assign burst_end_en = trig_cfg_q[TRG_BURST_END_BIT];
  assign origin = trig_cfg_q[TRG_ORIGIN_LSB +: 4];
  assign sense = sense_e'(trig_cfg_q[TRG_SENSE_LSB +: 3]);
  assign overlap = trig_cfg_q[TRG_OVERLAP_BIT];

  // Command decode
  logic wr_cmd, cmd_begin, cmd_end, host_trig, auto_once_done;
  assign wr_cmd = CE_IN && req.wr && (req.addr == REG_COMMAND);
  assign cmd_begin = wr_cmd && req.wdata[CMD_BEGIN_BIT];  // [R4]
  assign cmd_end = wr_cmd && req.wdata[CMD_END_BIT];  // [R4]
  assign host_trig = wr_cmd && req.wdata[CMD_HOST_TRIG_BIT] && (origin == ORIGIN_HOST);  // [R20]

  // Register writes; auto-once clears itself after adapting
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      control_q <= CONTROL_RST;
      trig_cfg_q <= TRIG_CFG_RST;
      multi_q <= MULTI_COUNT_RST;
      burst_q <= BURST_COUNT_RST;
      exp_q <= EXPOSURE_RST;
      delay_q <= 32'h0000_0000;
      rate_q <= FRAME_RATE_RST;
      row_q <= ROW_RATE_RST;
      readout_q <= READOUT_RST;
    end else if (CE_IN) begin
      if (req.wr) begin
        case (req.addr)
          REG_CONTROL: control_q <= req.wdata;
          REG_TRIG_CFG: trig_cfg_q <= req.wdata;
          REG_MULTI_COUNT: multi_q <= req.wdata;
          REG_BURST_COUNT: burst_q <= req.wdata;
          REG_EXPOSURE_US: exp_q <= req.wdata;
          REG_TRIG_DELAY_US: delay_q <= req.wdata;
          REG_FRAME_RATE: rate_q <= req.wdata;
          REG_ROW_RATE: row_q <= req.wdata;
          REG_READOUT_US: readout_q <= req.wdata;
          default: ;
        endcase
      end
      if (auto_once_done) begin
        control_q[CTL_AUTO_LSB +: 2] <= AUTO_OFF;  // [R9]
        exp_q <= AUTO_EXP_US;
      end
    end
  end

  // ==========================================================================
  // Trigger input path
  // ==========================================================================
  logic [NUM_SRC-1:0] src_raw, sync1_q, sync2_q;
  assign src_raw = {LOGIC_BLOCK_IN, COUNTER_IN, USER_BIT_IN, LINE_IN};  // [R16]

  // Two-stage synchroniser per source
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_sync
      always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (CE_IN) begin
          sync1_q[gi] <= src_raw[gi];  // [R23]
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic sel_lvl, prev_q, trig_lvl_act, trig_event, hw_event;
  assign sel_lvl = (origin < 4'(NUM_SRC)) ? sync2_q[origin] : 1'b0;

  // Previous level for edge detection
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) prev_q <= 1'b0;
    else if (CE_IN) prev_q <= sel_lvl;
  end

  // Sense selection
  assign trig_lvl_act = (sense == SENSE_LOW) ? ~sel_lvl : sel_lvl;
  assign hw_event = (sense == SENSE_LOW) ? (~sel_lvl) :
                    (sense == SENSE_HIGH) ? sel_lvl :
                    (sense == SENSE_FALL) ? (prev_q && !sel_lvl) :
                    (sense == SENSE_RISE) ? (!prev_q && sel_lvl) :
                    (sense == SENSE_ANY) ? (prev_q != sel_lvl) : 1'b0;  // [R17]
  assign trig_event = trig_en && ((origin == ORIGIN_HOST) ? host_trig : hw_event);  // [R10]

  // ==========================================================================
  // Microsecond tick
  // ==========================================================================
  logic [7:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 8'(TICK_US_CYCLES - 1));
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) tick_cnt_q <= 8'h00;
    else if (CE_IN) tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;  // [R23]
  end

  // ==========================================================================
  // Frame pacing: manual or automatic period, row pacing
  // ==========================================================================
  logic [31:0] exp_us, period_us, frame_us, row_cyc;
  assign exp_us = (auto_sel == AUTO_OFF) ? exp_q : AUTO_EXP_US;  // [R8]
  // Manual rate sets period; automatic runs as fast as exposure plus readout
  assign period_us = manual_rate ? (32'd1000000 / ((rate_q == 0) ? 32'd1 : rate_q))
                                 : (exp_us + readout_q);  // [R5]
  // Rate hold caps exposure so programmed period survives
  assign frame_us = (manual_rate && rate_hold) ? period_us :
                    ((exp_us > period_us) ? exp_us : period_us);  // [R21] [R6]
  assign row_cyc = 32'(CLK_FREQ_HZ) / ((row_q == 0) ? 32'd1 : row_q);  // [R22]

  // ==========================================================================
  // Capture sequencer
  // ==========================================================================
  typedef enum {S_IDLE, S_ARMED, S_DELAY, S_EXPOSE, S_GAP} state_e;
  state_e state_q, state_d;
  logic active_q, ro_q;
  logic [31:0] us_cnt_q, frame_cnt_q, todo_q, ro_cnt_q, row_cnt_q;
  logic [31:0] burst_n, batch_n, exp_lim;
  logic acq_trig_mode, frame_end, start_ok, armed_go;

  assign acq_trig_mode = trig_en && (ttype == TYPE_ACQ_START);
  // Images per trigger for burst type
  assign burst_n = (mode == SINGLE_CAPTURE_MODE) ? 32'd1 :
                   (mode == MULTI_CAPTURE_MODE) ? multi_q :
                   (!burst_end_en ? burst_q : 32'd1);  // [R14] [R15]
  assign batch_n = (mode == SINGLE_CAPTURE_MODE) ? 32'd1 :
                   (mode == MULTI_CAPTURE_MODE) ? multi_q : 32'hFFFF_FFFF;  // [R2] [R3]
  assign exp_lim = (manual_rate && rate_hold && exp_us > period_us) ? period_us : exp_us;
  assign start_ok = overlap || !ro_q;  // [R18]
  assign armed_go = trig_en && (ttype != TYPE_ACQ_START) && trig_event && start_ok;
  assign frame_end = (state_q == S_GAP) && tick && (us_cnt_q + 32'd1 >= frame_us);

  // Next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (cmd_begin && !acq_trig_mode) state_d = trig_en ? S_ARMED : S_DELAY;
              else if (acq_trig_mode && trig_event && start_ok) state_d = S_DELAY;  // [R11]
      S_ARMED: if (armed_go) state_d = S_DELAY;
      S_DELAY: if (tick && us_cnt_q >= delay_q) state_d = S_EXPOSE;  // [R19]
      S_EXPOSE: if (width_exp ? !trig_lvl_act : (tick && us_cnt_q + 32'd1 >= exp_lim)) state_d = S_GAP;
      S_GAP: if (frame_end) begin
               if (todo_q <= 32'd1) begin
                 state_d = (trig_en && ttype != TYPE_ACQ_START &&
                            (mode == CONTINUOUS_MODE || ttype == TYPE_BURST_BEGIN)) ? S_ARMED : S_IDLE;
               end else begin
                 state_d = S_DELAY;
               end
             end
      default: state_d = S_IDLE;
    endcase
    if (cmd_end) state_d = S_IDLE;  // [R4]
  end

  // Sequencer registers: state, timers, image budget, readout window
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= S_IDLE;
      us_cnt_q <= 32'h0000_0000;
      todo_q <= 32'h0000_0000;
      ro_q <= 1'b0;
      ro_cnt_q <= 32'h0000_0000;
      img_cnt_q <= 32'h0000_0000;
      frame_cnt_q <= 32'h0000_0000;
    end else if (CE_IN) begin
      state_q <= state_d;
      if (state_d != state_q) us_cnt_q <= 32'h0000_0000;
      else if (tick) us_cnt_q <= us_cnt_q + 32'd1;
      // Budget loaded when a batch is launched
      if (state_q == S_IDLE && state_d == S_DELAY) begin
        todo_q <= (ttype == TYPE_BURST_BEGIN && trig_en) ? burst_n : batch_n;
      end else if (state_q == S_ARMED && state_d == S_DELAY) begin
        todo_q <= (ttype == TYPE_BURST_BEGIN) ? burst_n :
                  (mode == CONTINUOUS_MODE) ? 32'd1 : batch_n;  // [R12] [R13]
      end else if (frame_end && todo_q != 32'hFFFF_FFFF) begin
        todo_q <= todo_q - 32'd1;
      end
      // Readout follows exposure end
      if (state_q == S_EXPOSE && state_d != S_EXPOSE) begin
        ro_q <= 1'b1;
        ro_cnt_q <= 32'h0000_0000;
        img_cnt_q <= img_cnt_q + 32'd1;
      end else if (ro_q && tick) begin
        ro_cnt_q <= ro_cnt_q + 32'd1;
        if (ro_cnt_q + 32'd1 >= readout_q) ro_q <= 1'b0;
      end
      // Frames seen by auto-once
      if (auto_sel != AUTO_ONCE) frame_cnt_q <= 32'h0000_0000;
      else if (frame_end) frame_cnt_q <= frame_cnt_q + 32'd1;
    end
  end
  assign auto_once_done = (auto_sel == AUTO_ONCE) && (frame_cnt_q >= 32'(AUTO_ONCE_FRAMES));  // [R9]

  // ==========================================================================
  // Achieved rate, row strobe and outputs
  // ==========================================================================
  logic row_pulse;
  assign row_pulse = (state_q == S_EXPOSE || ro_q) && (row_cnt_q + 32'd1 >= row_cyc);
  assign active_q = (state_q != S_IDLE);

  // Output and read-back registers
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      achieved_q <= 32'h0000_0000;
      row_cnt_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      SENSOR_OUT <= '0;
      ROW_STROBE_OUT <= 1'b0;
      IMAGE_DONE_OUT <= 1'b0;
    end else if (CE_IN) begin
      achieved_q <= (active_q && frame_us != 0) ? 32'd1000000 / frame_us : 32'h0000_0000;  // [R6]
      row_cnt_q <= row_pulse ? 32'h0000_0000 : row_cnt_q + 32'd1;
      ROW_STROBE_OUT <= row_pulse;  // [R22]
      IMAGE_DONE_OUT <= frame_end;
      SENSOR_OUT <= '{exposing: (state_q == S_EXPOSE), readout: ro_q, acq_active: active_q};
      rdata_q <= 32'h0000_0000;
      if (req.rd) begin
        case (req.addr)
          REG_CONTROL: rdata_q <= control_q;
          REG_TRIG_CFG: rdata_q <= trig_cfg_q;
          REG_MULTI_COUNT: rdata_q <= multi_q;
          REG_BURST_COUNT: rdata_q <= burst_q;
          REG_EXPOSURE_US: rdata_q <= exp_q;
          REG_TRIG_DELAY_US: rdata_q <= delay_q;
          REG_FRAME_RATE: rdata_q <= rate_q;
          REG_ROW_RATE: rdata_q <= row_q;
          REG_READOUT_US: rdata_q <= readout_q;
          REG_STATUS: rdata_q <= {28'h0, ro_q, state_q == S_EXPOSE, state_q == S_ARMED, active_q};
          REG_ACHIEVED_RATE: rdata_q <= achieved_q;
          REG_IMAGE_COUNT: rdata_q <= img_cnt_q;
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign RDATA_OUT = rdata_q;

endmodule : acq_trigger_ctrl

// ---- sim/acq_trigger_ctrl_monitor.sv ----
// Port-level checker for the acquisition trigger controller
`timescale 1ns/1ps
module acq_trigger_ctrl_monitor
  import acq_ctrl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire acq_ctrl_pkg::sensor_ctl_s SENSOR_OUT,
  input wire logic ROW_STROBE_OUT,
  input wire logic IMAGE_DONE_OUT
);
  // ==========================================================================
  // Helper decode
  // ==========================================================================
  logic trig_on_q;
  wire rd_take = RD_IN && CE_IN;
  wire cmd_wr = WR_IN && CE_IN && ADDR_IN == REG_COMMAND;
  wire begin_wr = cmd_wr && WDATA_IN[CMD_BEGIN_BIT];
  wire end_wr = cmd_wr && WDATA_IN[CMD_END_BIT];
  wire busy = SENSOR_OUT.exposing || SENSOR_OUT.readout;
  // Shadow of the trigger enables
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      trig_on_q <= 1'b0;
    end else if (WR_IN && CE_IN && ADDR_IN == REG_TRIG_CFG) begin
      trig_on_q <= |WDATA_IN[4:2];
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_cmd_reads_zero: assert property (rd_take && ADDR_IN == REG_COMMAND |=> RDATA_OUT == 32'h0)
    else $error("command word read back nonzero");
  a_rdata_after_read: assert property (RDATA_OUT != 32'h0 |-> $past(rd_take))
    else $error("read data outside its cycle");
  a_end_halts_acq: assert property (end_wr |-> ##[1:2] !SENSOR_OUT.acq_active)
    else $error("end command did not halt capture");
  a_expose_in_acq: assert property (SENSOR_OUT.exposing |-> SENSOR_OUT.acq_active)
    else $error("exposing outside acquisition");
  a_trig_off_idle: assert property ($rose(SENSOR_OUT.acq_active) && !trig_on_q |->
    $past(begin_wr) || $past(begin_wr, 2) || $past(begin_wr, 3))
    else $error("acquisition began without command");
  a_row_one_cycle: assert property (ROW_STROBE_OUT && CE_IN |=> !ROW_STROBE_OUT)
    else $error("row strobe longer than one cycle");
  a_row_in_frame: assert property (ROW_STROBE_OUT |-> (busy || $past(busy)) or ##1 busy)
    else $error("row strobe outside a frame");
  a_done_one_cycle: assert property (IMAGE_DONE_OUT && CE_IN |=> !IMAGE_DONE_OUT)
    else $error("image done longer than one cycle");
  c_exposure: cover property ($rose(SENSOR_OUT.exposing));
  c_image_done: cover property (IMAGE_DONE_OUT);
  c_end_running: cover property (end_wr && SENSOR_OUT.acq_active);
endmodule : acq_trigger_ctrl_monitor

bind acq_trigger_ctrl acq_trigger_ctrl_monitor i_monitor (
  .CLK_IN(CLK_IN),
  .RESET_IN(RESET_IN),
  .CE_IN(CE_IN),
  .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN),
  .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT),
  .SENSOR_OUT(SENSOR_OUT),
  .ROW_STROBE_OUT(ROW_STROBE_OUT),
  .IMAGE_DONE_OUT(IMAGE_DONE_OUT)
);

// ---- sim/trig_source_model.sv ----
// Model of the external trigger sources wired to the controller
`timescale 1ns/1ps
module trig_source_model (
  input wire logic clk_in,
  output logic [9:0] src_out
);
  // ==========================================================================
  // Source drive
  // ==========================================================================
  // Lines idle low and change only just after a clock edge
  initial begin
    src_out = 10'h000;
  end
  // One pulse of width whole cycles on one source, unrelated to any bus traffic
  task automatic pulse(input int idx, input int width);
    @(posedge clk_in);
    src_out[idx] <= 1'b1;
    repeat (width) @(posedge clk_in);
    src_out[idx] <= 1'b0;
  endtask : pulse
endmodule : trig_source_model

// ---- sim/acq_trigger_ctrl_tb.sv ----
// Self-checking testbench for the acquisition trigger controller
`timescale 1ns/1ps
module acq_trigger_ctrl_tb;
  import acq_ctrl_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] w; logic [31:0] rb;} row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  bus_req_s req = '0;
  logic [31:0] rdata, rv;
  sensor_ctl_s sensor;
  logic row_stb, done;
  wire [9:0] src;
  int mismatches = 0;
  int comparisons = 0;
  int dn = 0;
  int exp_cyc = 0;
  int cycles = 0;
  int b, e;
  row_s rows [13] = '{'{REG_CONTROL, CONTROL_RST, 32'h0, 32'h0},
    '{REG_TRIG_CFG, TRIG_CFG_RST, 32'h3A08, 32'h3A08}, '{REG_MULTI_COUNT, MULTI_COUNT_RST, 32'h3, 32'h3},
    '{REG_BURST_COUNT, BURST_COUNT_RST, 32'h2, 32'h2}, '{REG_EXPOSURE_US, EXPOSURE_RST, 32'h2, 32'h2},
    '{REG_TRIG_DELAY_US, 32'h0, 32'h1, 32'h1}, '{REG_FRAME_RATE, FRAME_RATE_RST, 32'h186A0, 32'h186A0},
    '{REG_ROW_RATE, ROW_RATE_RST, 32'h61A80, 32'h61A80}, '{REG_READOUT_US, READOUT_RST, 32'h1, 32'h1},
    '{REG_COMMAND, 32'h0, 32'h0, 32'h0}, '{REG_STATUS, 32'h0, 32'hF, 32'h0},
    '{REG_IMAGE_COUNT, 32'h0, 32'h5, 32'h0}, '{8'h3C, 32'h0, 32'h1, 32'h0}};

  acq_trigger_ctrl i_dut (.CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .ADDR_IN(req.addr),
    .WDATA_IN(req.wdata), .WR_IN(req.wr), .RD_IN(req.rd), .LINE_IN(src[3:0]),
    .USER_BIT_IN(src[5:4]), .COUNTER_IN(src[7:6]), .LOGIC_BLOCK_IN(src[9:8]),
    .RDATA_OUT(rdata), .SENSOR_OUT(sensor), .ROW_STROBE_OUT(row_stb), .IMAGE_DONE_OUT(done));
  trig_source_model i_src (.clk_in(clk), .src_out(src));

  // Clock, 5 ns period
  always #2.5 clk = ~clk;
  // Image, exposure and hang counters
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (done === 1'b1) dn <= dn + 1;
    if (sensor.exposing === 1'b1) exp_cyc <= exp_cyc + 1;
    if (cycles == 90000) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, cycles, 0);
      tally_and_finish();
    end
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  task automatic cmd(input logic [31:0] c);
    wr(REG_COMMAND, c);
  endtask : cmd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Optional command, then count the images since the base mark
  task automatic shot(input logic [31:0] c, input int n);
    if (c != 0) cmd(c);
    cyc(3000);
    chk(dn - b, n);
  endtask : shot
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      rd(rows[i].a, rv);
      chk(rv, rows[i].rst);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rv);
      chk(rv, rows[i].rb);
    end
    $display("-- registers done");
    wr(REG_TRIG_CFG, 32'h0);
    wr(REG_CONTROL, 32'h1);
    b = dn;
    e = exp_cyc;
    cmd(32'h1);
    cyc(150);
    chk(exp_cyc - e, 0);
    shot(0, 1);
    chk((exp_cyc - e) inside {[396:404]}, 1);
    chk(sensor.acq_active, 0);
    wr(REG_CONTROL, 32'h2);
    b = dn;
    cmd(32'h1);
    cyc(1500);
    shot(0, 3);
    chk(sensor.acq_active, 0);
    $display("-- single and multi done");
    wr(REG_CONTROL, 32'h0);
    b = dn;
    cmd(32'h1);
    cyc(4500);
    chk(dn - b >= 3, 1);
    cmd(32'h2);
    cyc(3);
    chk(sensor.acq_active, 0);
    b = dn;
    shot(0, 0);
    $display("-- continuous done");
    wr(REG_TRIG_CFG, 32'h3A01);
    shot(4, 0);
    wr(REG_TRIG_CFG, 32'h3A09);
    shot(1, 0);
    shot(4, 1);
    shot(4, 2);
    wr(REG_TRIG_CFG, 32'h3009);
    shot(4, 2);
    cmd(32'h2);
    wr(REG_TRIG_CFG, 32'h3A09);
    wr(REG_CONTROL, 32'h1);
    b = dn;
    cmd(32'h1);
    shot(4, 1);
    shot(4, 1);
    cmd(32'h1);
    shot(4, 2);
    wr(REG_TRIG_CFG, 32'h3A04);
    b = dn;
    shot(1, 0);
    shot(4, 1);
    chk(sensor.acq_active, 0);
    $display("-- host trigger done");
    cmd(32'h2);
    wr(REG_CONTROL, 32'h0);
    wr(REG_TRIG_CFG, 32'h3A12);
    b = dn;
    cmd(32'h1);
    shot(4, 2);
    shot(4, 4);
    cmd(32'h2);
    wr(REG_CONTROL, 32'h1);
    cmd(32'h1);
    shot(4, 5);
    $display("-- burst done");
    wr(REG_CONTROL, 32'h0);
    for (int i = 0; i < NUM_SRC; i++) begin
      cmd(32'h2);
      wr(REG_TRIG_CFG, {16'h0, 1'b0, 3'(i % 5), 4'(i), 8'h09});
      cmd(32'h1);
      b = dn;
      i_src.pulse(i, 20);
      cyc(1500);
      chk(dn - b > 0, 1);
    end
    $display("-- sources done");
    cmd(32'h2);
    wr(REG_TRIG_CFG, 32'h0);
    wr(REG_CONTROL, 32'h20);
    cmd(32'h1);
    cyc(3000);
    rd(REG_ACHIEVED_RATE, rv);
    chk(rv, 32'h186A0);
    wr(REG_EXPOSURE_US, 32'h14);
    cyc(3000);
    rd(REG_ACHIEVED_RATE, rv);
    chk(rv < 32'h186A0, 1);
    wr(REG_CONTROL, 32'h60);
    cyc(3000);
    rd(REG_ACHIEVED_RATE, rv);
    chk(rv, 32'h186A0);
    ce <= 1'b0;
    b = dn;
    cyc(3000);
    chk(dn - b, 0);
    ce <= 1'b1;
    $display("-- rate and hold done");
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    @(posedge clk);
    chk(sensor.acq_active, 0);
    rd(REG_CONTROL, rv);
    chk(rv, CONTROL_RST);
    rd(REG_TRIG_CFG, rv);
    chk(rv, TRIG_CFG_RST);
    $display("-- reset done");
    tally_and_finish();
  end
endmodule : acq_trigger_ctrl_tb
